// File: src/pao_pkg.sv
`default_nettype none
// shared constants for the phase accumulator oscillator
package pao_pkg;

  // register byte addresses on the bus (word aligned)
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CLOCK_SELECT = 8'h04;
  localparam logic [7:0] OFF_ACC_LOW = 8'h08;
  localparam logic [7:0] OFF_ACC_HIGH = 8'h0C;
  localparam logic [7:0] OFF_ACC_UPPER = 8'h10;
  localparam logic [7:0] OFF_INC_LOW = 8'h14;
  localparam logic [7:0] OFF_INC_HIGH = 8'h18;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  // control register fields
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_PIN_OE_BIT = 6;
  localparam int CTRL_LEVEL_BIT = 5;
  localparam int CTRL_POLARITY_BIT = 4;
  localparam int CTRL_PULSE_MODE_BIT = 0;

  // clock select register fields
  localparam int CLKSEL_PWS_LSB = 5;
  localparam int CLKSEL_PWS_MSB = 7;
  localparam int CLKSEL_SRC_LSB = 0;
  localparam int CLKSEL_SRC_MSB = 1;

  // interrupt status / mask fields
  localparam int IRQ_OVERFLOW_BIT = 0;
  localparam int IRQ_POLARITY_BIT = 1;

  // widths
  localparam int ACC_WIDTH = 20;
  localparam int INC_WIDTH = 16;
  localparam int PULSE_CNT_WIDTH = 8;

  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_SELECT = 8'h00;
  localparam logic [19:0] RST_ACC = 20'h00000;
  localparam logic [7:0] RST_INC_LOW = 8'h01;
  localparam logic [7:0] RST_INC_HIGH = 8'h00;
  localparam logic [15:0] RST_INC_BUF = 16'h0001;
  localparam logic [1:0] RST_IRQ = 2'h0;

  // increment arm count: load on the second input clock edge after a low byte write
  localparam logic [1:0] INC_ARM_EDGES = 2'h2;

  // accumulator clock sources
  typedef enum logic [1:0] {
    SRC_FAST_OSC,
    SRC_SYSTEM,
    SRC_LOGIC_CELL1,
    SRC_EXT_PIN
  } pao_clksrc_type;

endpackage : pao_pkg
`default_nettype wire

// File: src/pao_clock_tick.sv
`timescale 1ns/10ps
`default_nettype none
// turns the selected accumulator clock into one-cycle ticks on mclk
module pao_clock_tick (
  input wire logic mclk,              // system clock
  input wire logic srst,              // synchronous reset, active high
  input wire logic [1:0] clockSource, // selected source code
  input wire logic [2:0] asyncClocks, // fast osc, logic cell 1, ext pin
  output logic tick                   // one pulse per selected rising edge
);

  logic [2:0] syncFirst;
  logic [2:0] syncSecond;
  logic [2:0] syncPrev;
  logic [2:0] riseSeen;

  // two-flop synchroniser plus a history flop per asynchronous source
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (srst) begin
          syncFirst[g] <= 1'b0;
          syncSecond[g] <= 1'b0;
          syncPrev[g] <= 1'b0;
        end else begin
          syncFirst[g] <= asyncClocks[g];
          syncSecond[g] <= syncFirst[g];
          syncPrev[g] <= syncSecond[g];
        end
      end
      assign riseSeen[g] = syncSecond[g] & ~syncPrev[g];
    end
  endgenerate

  // sources must be slower than half of mclk or edges are lost
  always_comb begin
    case (pao_pkg::pao_clksrc_type'(clockSource))
      pao_pkg::SRC_FAST_OSC: tick = riseSeen[0];
      pao_pkg::SRC_SYSTEM: tick = 1'b1;
      pao_pkg::SRC_LOGIC_CELL1: tick = riseSeen[1];
      default: tick = riseSeen[2];
    endcase
  end

endmodule : pao_clock_tick
`default_nettype wire

// File: src/pao_oscillator.sv
//Behaviour
//- control bit 7 enables the oscillator; resets to off
//- control bit 6 lets the oscillator output drive the pin
//- control bit 5 is read-only and shows the present output level
//- control bit 4 set inverts the output (active low)
//- control bit 0 selects pulse mode; bits 3-1 read zero
//- clock select bits 7-5 give pulse length of two to the code periods
//- pulse width is ignored in fixed duty mode
//- clock select bits 1-0 pick the accumulator clock; bits 4-2 read zero
//- accumulator reads and writes as low, high and upper nibble bytes
//- increment is two read/write bytes, low and high
//- reset clears everything except increment low bit 0, which sets
//- each selected clock edge adds increment; carry out is overflow
//- fixed duty mode toggles output on every overflow
//- pulse mode goes active on edge after overflow for the width
//- increment loads two edges after low write when on, at once when off
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module pao_oscillator (
  input wire logic mclk,             // system clock, 20 MHz
  input wire logic srst,             // synchronous reset, active high
  input wire logic hsel,             // ahb slave select
  input wire logic [31:0] haddr,     // ahb address
  input wire logic [1:0] htrans,     // ahb transfer type
  input wire logic hwrite,           // ahb write
  input wire logic [2:0] hsize,      // ahb size, word only
  input wire logic [31:0] hwdata,    // ahb write data
  input wire logic hready,           // ahb bus ready
  output logic hreadyout,            // ahb slave ready
  output logic hresp,                // ahb response, always okay
  output logic [31:0] hrdata,        // ahb read data
  input wire logic internalFastOsc,  // internal fast oscillator clock
  input wire logic logicCell1Output, // logic cell 1 output
  input wire logic externalOscClockPin, // dedicated clock input pin
  output logic oscOut,               // output to internal peripherals
  output logic pinOut,               // pin output value
  output logic pinOe,                // pin output enable
  output logic irq                   // level interrupt request
);

  // software visible state
  logic [7:0] control;
  logic [7:0] clockSelect;
  logic [19:0] phaseAccumulator;
  logic [7:0] incLow;
  logic [7:0] incHigh;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  // hidden working state
  logic [15:0] incBuffer;
  logic [1:0] incArm;
  logic incLoadNow;
  logic outRaw;
  logic pulsePending;
  logic [7:0] pulseCount;
  // bus data phase
  logic wrPending;
  logic [7:0] wrAddr;
  logic [7:0] wrByte;
  logic [31:0] next_hrdata;
  logic wrControl, wrClock, wrAccL, wrAccH, wrAccU, wrIncL, wrIncH, wrStatus, wrMask, accWrite;
  // datapath
  logic tick;
  logic oscEnable;
  logic pulseMode;
  logic polarity;
  logic outputLevel;
  logic [20:0] sum;
  logic overflow;
  logic [7:0] pulseWidth;
  logic polarityEvent;

  assign oscEnable = control[pao_pkg::CTRL_ENABLE_BIT];
  assign pulseMode = control[pao_pkg::CTRL_PULSE_MODE_BIT];
  assign polarity = control[pao_pkg::CTRL_POLARITY_BIT];
  assign pulseWidth = 8'h01 << clockSelect[pao_pkg::CLKSEL_PWS_MSB:pao_pkg::CLKSEL_PWS_LSB];

  // selected accumulator clock as mclk ticks
  pao_clock_tick u_tick (
    .mclk(mclk),
    .srst(srst),
    .clockSource(clockSelect[pao_pkg::CLKSEL_SRC_MSB:pao_pkg::CLKSEL_SRC_LSB]),
    .asyncClocks({externalOscClockPin, logicCell1Output, internalFastOsc}),
    .tick(tick)
  );

  // adder with carry out as the raw overflow
  assign sum = {1'b0, phaseAccumulator} + {5'h00, incBuffer};
  assign overflow = tick & oscEnable & sum[20];

  // bus: zero wait states, every transfer answered okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // latch the address phase of writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      wrPending <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPending <= hsel & htrans[1] & hready & hwrite;
      wrAddr <= haddr[7:0];
    end
  end
  assign wrByte = hwdata[7:0];

  // write strobes in the data phase
  always_comb begin
    wrControl = 1'b0;
    wrClock = 1'b0;
    wrAccL = 1'b0;
    wrAccH = 1'b0;
    wrAccU = 1'b0;
    wrIncL = 1'b0;
    wrIncH = 1'b0;
    wrStatus = 1'b0;
    wrMask = 1'b0;
    if (!wrPending) begin
      wrControl = 1'b0;
    end else if (wrAddr == pao_pkg::OFF_CONTROL) begin
      wrControl = 1'b1;
    end else if (wrAddr == pao_pkg::OFF_CLOCK_SELECT) begin
      wrClock = 1'b1;
    end else if (wrAddr == pao_pkg::OFF_ACC_LOW) begin
      wrAccL = 1'b1;
    end else if (wrAddr == pao_pkg::OFF_ACC_HIGH) begin
      wrAccH = 1'b1;
    end else if (wrAddr == pao_pkg::OFF_ACC_UPPER) begin
      wrAccU = 1'b1;
    end else if (wrAddr == pao_pkg::OFF_INC_LOW) begin
      wrIncL = 1'b1;
    end else if (wrAddr == pao_pkg::OFF_INC_HIGH) begin
      wrIncH = 1'b1;
    end else if (wrAddr == pao_pkg::OFF_IRQ_STATUS) begin
      wrStatus = 1'b1;
    end else if (wrAddr == pao_pkg::OFF_IRQ_MASK) begin
      wrMask = 1'b1;
    end
  end
  assign accWrite = wrAccL | wrAccH | wrAccU;

  // read mux in the address phase; unmapped reads return zero
  always_comb begin
    next_hrdata = 32'h00000000;
    if (haddr[7:0] == pao_pkg::OFF_CONTROL) begin
      next_hrdata[7:0] = {control[7:6], outputLevel, control[4], 3'h0, control[0]};
    end else if (haddr[7:0] == pao_pkg::OFF_CLOCK_SELECT) begin
      next_hrdata[7:0] = {clockSelect[7:5], 3'h0, clockSelect[1:0]};
    end else if (haddr[7:0] == pao_pkg::OFF_ACC_LOW) begin
      next_hrdata[7:0] = phaseAccumulator[7:0];
    end else if (haddr[7:0] == pao_pkg::OFF_ACC_HIGH) begin
      next_hrdata[7:0] = phaseAccumulator[15:8];
    end else if (haddr[7:0] == pao_pkg::OFF_ACC_UPPER) begin
      next_hrdata[7:0] = {4'h0, phaseAccumulator[19:16]};
    end else if (haddr[7:0] == pao_pkg::OFF_INC_LOW) begin
      next_hrdata[7:0] = incLow;
    end else if (haddr[7:0] == pao_pkg::OFF_INC_HIGH) begin
      next_hrdata[7:0] = incHigh;
    end else if (haddr[7:0] == pao_pkg::OFF_IRQ_STATUS) begin
      next_hrdata[1:0] = irqStatus;
    end else if (haddr[7:0] == pao_pkg::OFF_IRQ_MASK) begin
      next_hrdata[1:0] = irqMask;
    end
  end

  // read data captured at the address phase, so it holds a flop output
  always_ff @(posedge mclk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (hsel & htrans[1] & hready & ~hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // control register; bits 5 and 3-1 hold no storage
  always_ff @(posedge mclk) begin
    if (srst) begin
      control <= pao_pkg::RST_CONTROL;
    end else if (wrControl) begin
      control <= {wrByte[7:6], 1'b0, wrByte[4], 3'h0, wrByte[0]};
    end
  end
  assign polarityEvent = wrControl & (wrByte[pao_pkg::CTRL_POLARITY_BIT] != polarity);

  // clock select register; bits 4-2 hold no storage
  always_ff @(posedge mclk) begin
    if (srst) begin
      clockSelect <= pao_pkg::RST_CLOCK_SELECT;
    end else if (wrClock) begin
      clockSelect <= {wrByte[7:5], 3'h0, wrByte[1:0]};
    end
  end

  // accumulator: software byte writes win over the adder in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      phaseAccumulator <= pao_pkg::RST_ACC;
    end else if (accWrite) begin
      if (wrAccL) begin
        phaseAccumulator[7:0] <= wrByte;
      end
      if (wrAccH) begin
        phaseAccumulator[15:8] <= wrByte;
      end
      if (wrAccU) begin
        phaseAccumulator[19:16] <= wrByte[3:0];
      end
    end else if (tick && oscEnable) begin
      phaseAccumulator <= sum[19:0];
    end
  end

  // increment registers, software side
  always_ff @(posedge mclk) begin
    if (srst) begin
      incLow <= pao_pkg::RST_INC_LOW;
      incHigh <= pao_pkg::RST_INC_HIGH;
    end else begin
      if (wrIncL) begin
        incLow <= wrByte;
      end
      if (wrIncH) begin
        incHigh <= wrByte;
      end
    end
  end

  // working increment buffer; software order high then low is relied upon
  always_ff @(posedge mclk) begin
    if (srst) begin
      incBuffer <= pao_pkg::RST_INC_BUF;
      incArm <= 2'h0;
      incLoadNow <= 1'b0;
    end else begin
      incLoadNow <= ~oscEnable & (wrIncL | wrIncH);
      if (incLoadNow) begin
        incBuffer <= {incHigh, incLow};
      end else if (tick && oscEnable && incArm == 2'h1) begin
        incBuffer <= {incHigh, incLow};
      end
      if (wrIncL && oscEnable) begin
        incArm <= pao_pkg::INC_ARM_EDGES;
      end else if (!oscEnable) begin
        incArm <= 2'h0;
      end else if (tick && incArm != 2'h0) begin
        incArm <= incArm - 2'h1;
      end
    end
  end

  // output shaping; a width longer than the overflow period is not guarded
  always_ff @(posedge mclk) begin
    if (srst) begin
      outRaw <= 1'b0;
      pulsePending <= 1'b0;
      pulseCount <= 8'h00;
    end else if (!oscEnable) begin
      pulsePending <= 1'b0;
    end else if (!pulseMode) begin
      pulsePending <= 1'b0;
      if (overflow) begin
        outRaw <= ~outRaw;
      end
    end else if (tick) begin
      pulsePending <= sum[20];
      if (pulsePending) begin
        outRaw <= 1'b1;
        pulseCount <= pulseWidth - 8'h01;
      end else if (outRaw && pulseCount != 8'h00) begin
        pulseCount <= pulseCount - 8'h01;
      end else begin
        outRaw <= 1'b0;
      end
    end
  end

  // polarity stage and pin drive
  assign outputLevel = outRaw ^ polarity;
  assign oscOut = outputLevel;
  assign pinOut = outputLevel;
  assign pinOe = control[pao_pkg::CTRL_PIN_OE_BIT];

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      irqStatus <= pao_pkg::RST_IRQ;
      irqMask <= pao_pkg::RST_IRQ;
    end else begin
      if (wrMask) begin
        irqMask <= wrByte[1:0];
      end
      irqStatus[pao_pkg::IRQ_OVERFLOW_BIT] <= overflow |
        (irqStatus[pao_pkg::IRQ_OVERFLOW_BIT] & ~(wrStatus & wrByte[pao_pkg::IRQ_OVERFLOW_BIT]));
      irqStatus[pao_pkg::IRQ_POLARITY_BIT] <= polarityEvent |
        (irqStatus[pao_pkg::IRQ_POLARITY_BIT] & ~(wrStatus & wrByte[pao_pkg::IRQ_POLARITY_BIT]));
    end
  end
  assign irq = oscEnable & |(irqStatus & irqMask);

  // checks
  property p_disabled_hold;
    @(posedge mclk) disable iff (srst) !oscEnable && !accWrite |=> $stable(phaseAccumulator);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("accumulator moved while off");

  property p_pin_follows;
    @(posedge mclk) disable iff (srst) pinOe |-> (pinOut == (outRaw ^ control[pao_pkg::CTRL_POLARITY_BIT]));
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("pin not driven by output");

  property p_ctrl_read;
    @(posedge mclk) disable iff (srst) hsel && htrans[1] && hready && !hwrite && haddr[7:0] == pao_pkg::OFF_CONTROL
      |=> hrdata[5] == $past(outputLevel) && hrdata[3:1] == 3'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

  property p_add;
    @(posedge mclk) disable iff (srst) tick && oscEnable && !accWrite
      |=> phaseAccumulator == $past(phaseAccumulator) + 20'($past(incBuffer));
  endproperty
  a_add: assert property (p_add) else $error("accumulator sum wrong");

  property p_toggle;
    @(posedge mclk) disable iff (srst) overflow && !pulseMode |=> outRaw != $past(outRaw);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on overflow");

  property p_pulse_start;
    @(posedge mclk) disable iff (srst) tick && pulsePending && pulseMode && oscEnable
      |=> outRaw && pulseCount == $past(pulseWidth) - 8'h01;
  endproperty
  a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

  property p_load_off;
    @(posedge mclk) disable iff (srst) wrIncL && !oscEnable && !wrControl ##1 !wrIncL && !wrIncH
      |=> incBuffer == {incHigh, incLow};
  endproperty
  a_load_off: assert property (p_load_off) else $error("increment not loaded");

  property p_flag;
    @(posedge mclk) disable iff (srst) overflow |=> irqStatus[pao_pkg::IRQ_OVERFLOW_BIT];
  endproperty
  a_flag: assert property (p_flag) else $error("overflow flag lost");

  property p_reset;
    @(posedge mclk) srst |=> incLow == pao_pkg::RST_INC_LOW && phaseAccumulator == pao_pkg::RST_ACC
      && control == pao_pkg::RST_CONTROL && !irq;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");

  c_overflow_fdc: cover property (@(posedge mclk) disable iff (srst) overflow && !pulseMode);
  c_overflow_pf: cover property (@(posedge mclk) disable iff (srst) overflow && pulseMode);
  c_irq: cover property (@(posedge mclk) disable iff (srst) irq);
  c_polarity: cover property (@(posedge mclk) disable iff (srst) polarityEvent);

endmodule : pao_oscillator
`default_nettype wire

// File: dv/pao_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// far side: three free-running clock sources and the pin that the block may drive
module pao_far_side (
  input wire logic pinOut,          // pin value from the block
  input wire logic pinOe,           // high while the block drives the pin
  output logic internalFastOsc,     // source 00, six mclk periods
  output logic logicCell1Output,    // source 10, eight mclk periods
  output logic externalOscClockPin, // source 11, ten mclk periods
  output logic pinWire              // level seen on the pin
);
  // one process per source, so each has a single driver
  // all edges fall on mclk falling edges, so no edge ties with the sampling edge
  initial begin
    internalFastOsc = 1'b0;
    forever #150 internalFastOsc = ~internalFastOsc;
  end
  initial begin
    logicCell1Output = 1'b0;
    forever #200 logicCell1Output = ~logicCell1Output;
  end
  initial begin
    externalOscClockPin = 1'b0;
    forever #250 externalOscClockPin = ~externalOscClockPin;
  end

  // a weak pull-down holds the pin low once the block lets go
  assign pinWire = pinOe ? pinOut : 1'b0;
endmodule : pao_far_side
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, oscOut, pinOut, pinOe, irq, pinWire, fastOsc, cellOut, extPin;
  int nFail = 0;
  int samplesChecked = 0;

  // 20 MHz system clock
  always #25 mclk = ~mclk;

  // one slave, so its ready is the bus ready; size stays at word
  pao_oscillator pao_oscillator_i (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .internalFastOsc(fastOsc), .logicCell1Output(cellOut),
    .externalOscClockPin(extPin), .oscOut(oscOut), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));

  pao_far_side pao_far_side_i (.pinOut(pinOut), .pinOe(pinOe), .internalFastOsc(fastOsc),
    .logicCell1Output(cellOut), .externalOscClockPin(extPin), .pinWire(pinWire));

  // compare tasks: every call is counted, a miss is reported at once
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string m);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check8
  task automatic checkBit(input logic got, input logic exp, input string m);
    check8({7'h00, got}, {7'h00, exp}, m);
  endtask : checkBit
  task automatic checkCnt(input int got, input int exp, input string m);
    samplesChecked++;
    if (got != exp) begin
      nFail++;
      $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask : checkCnt

  task automatic finish_test();
    $display("checks %0d failures %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic resetDut();
    srst <= 1'b1;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
  endtask : resetDut

  // single word transfer; signals change just after a rising edge and hold until ready is seen
  task automatic bus(input logic isWrite, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= isWrite;
    haddr <= {24'h000000, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e, input string m);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    check8(r, e, m);
  endtask : rdChk

  // cycles until the output next changes; sampled on falling edges, away from the updating edge
  task automatic toChange(output int n);
    logic v;
    v = oscOut;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (oscOut === v && n < 2000);
  endtask : toChange

  // defaults, with a running source that a disabled accumulator must ignore
  task automatic tReset();
    repeat (40) @(posedge mclk);
    rdChk(pao_pkg::OFF_CONTROL, 8'h00, "control");
    rdChk(pao_pkg::OFF_CLOCK_SELECT, 8'h00, "clock select");
    rdChk(pao_pkg::OFF_ACC_LOW, 8'h00, "acc low frozen");
    rdChk(pao_pkg::OFF_ACC_HIGH, 8'h00, "acc high");
    rdChk(pao_pkg::OFF_ACC_UPPER, 8'h00, "acc upper");
    rdChk(pao_pkg::OFF_INC_LOW, 8'h01, "inc low");
    rdChk(pao_pkg::OFF_INC_HIGH, 8'h00, "inc high");
    rdChk(pao_pkg::OFF_IRQ_STATUS, 8'h00, "status");
    rdChk(pao_pkg::OFF_IRQ_MASK, 8'h00, "mask");
    @(negedge mclk);
    checkBit(oscOut, 1'b0, "out idle");
    checkBit(pinOe, 1'b0, "pin released");
    checkBit(irq, 1'b0, "irq idle");
    checkBit(hresp, 1'b0, "okay response");
  endtask : tReset

  // field access, polarity event and its interrupt, pin enable
  task automatic tRegs();
    wr(pao_pkg::OFF_CONTROL, 8'h7F);
    rdChk(pao_pkg::OFF_CONTROL, 8'h71, "control fields");
    @(negedge mclk);
    checkBit(oscOut, 1'b1, "inverted idle");
    checkBit(pinWire, 1'b1, "pin driven");
    rdChk(pao_pkg::OFF_IRQ_STATUS, 8'h02, "polarity event");
    wr(pao_pkg::OFF_IRQ_MASK, 8'h02);
    @(negedge mclk);
    checkBit(irq, 1'b0, "irq needs enable");
    wr(pao_pkg::OFF_CONTROL, 8'hD0);
    @(negedge mclk);
    checkBit(irq, 1'b1, "irq raised");
    wr(pao_pkg::OFF_IRQ_STATUS, 8'h02);
    @(negedge mclk);
    checkBit(irq, 1'b0, "irq cleared");
    rdChk(pao_pkg::OFF_IRQ_STATUS, 8'h00, "status cleared");
    wr(pao_pkg::OFF_CONTROL, 8'h00);
    @(negedge mclk);
    checkBit(pinWire, 1'b0, "pin released");
    wr(pao_pkg::OFF_CLOCK_SELECT, 8'hFF);
    rdChk(pao_pkg::OFF_CLOCK_SELECT, 8'hE3, "clock fields");
    wr(pao_pkg::OFF_ACC_UPPER, 8'hFF);
    rdChk(pao_pkg::OFF_ACC_UPPER, 8'h0F, "acc nibble");
    wr(pao_pkg::OFF_ACC_LOW, 8'hA5);
    wr(pao_pkg::OFF_ACC_HIGH, 8'h5A);
    rdChk(pao_pkg::OFF_ACC_LOW, 8'hA5, "acc low");
    rdChk(pao_pkg::OFF_ACC_HIGH, 8'h5A, "acc high");
    wr(pao_pkg::OFF_INC_HIGH, 8'h3C);
    wr(pao_pkg::OFF_INC_LOW, 8'hC3);
    rdChk(pao_pkg::OFF_INC_LOW, 8'hC3, "inc low");
    rdChk(pao_pkg::OFF_INC_HIGH, 8'h3C, "inc high");
    wr(8'h24, 8'hFF);
    rdChk(8'h24, 8'h00, "unmapped");
  endtask : tRegs

  // fixed duty half periods from every source; the widest pulse code must not matter
  task automatic tSources();
    logic [1:0] src[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int per[4] = '{6, 8, 10, 1};
    int n;
    wr(pao_pkg::OFF_INC_HIGH, 8'h80); // high byte first
    wr(pao_pkg::OFF_INC_LOW, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(pao_pkg::OFF_CONTROL, 8'h00);
      wr(pao_pkg::OFF_CLOCK_SELECT, {6'h38, src[s]});
      wr(pao_pkg::OFF_CONTROL, 8'h80);
      @(negedge mclk);
      toChange(n);
      toChange(n);
      checkCnt(n, 32 * per[s], "half period");
      toChange(n);
      checkCnt(n, 32 * per[s], "half period");
    end
    wr(pao_pkg::OFF_INC_HIGH, 8'h40);
    wr(pao_pkg::OFF_INC_LOW, 8'h00);
    @(negedge mclk);
    repeat (3) toChange(n);
    checkCnt(n, 64, "new increment");
  endtask : tSources

  // every pulse width code, then the overflow interrupt raised, masked and cleared
  task automatic tPulse();
    int n;
    wr(pao_pkg::OFF_INC_HIGH, 8'h08); // 512-tick period outlasts any pulse
    wr(pao_pkg::OFF_INC_LOW, 8'h00);
    wr(pao_pkg::OFF_IRQ_MASK, 8'h01);
    for (int c = 0; c < 8; c++) begin
      wr(pao_pkg::OFF_CONTROL, 8'h00);
      wr(pao_pkg::OFF_CLOCK_SELECT, {3'(c), 5'h01});
      wr(pao_pkg::OFF_CONTROL, 8'h81);
      @(negedge mclk);
      toChange(n);
      checkBit(oscOut, 1'b1, "pulse start");
      toChange(n);
      checkCnt(n, 1 << c, "pulse width");
    end
    checkBit(irq, 1'b1, "overflow irq");
    wr(pao_pkg::OFF_IRQ_MASK, 8'h00);
    @(negedge mclk);
    checkBit(irq, 1'b0, "masked");
    wr(pao_pkg::OFF_IRQ_MASK, 8'h01);
    wr(pao_pkg::OFF_CONTROL, 8'h00);
    @(negedge mclk);
    checkBit(irq, 1'b0, "disabled");
    wr(pao_pkg::OFF_IRQ_STATUS, 8'h01);
    rdChk(pao_pkg::OFF_IRQ_STATUS, 8'h00, "flag cleared");
    wr(pao_pkg::OFF_CONTROL, 8'h81);
  endtask : tPulse

  // main sequence; the last reset lands while the oscillator runs
  initial begin
    resetDut();
    tReset();
    tRegs();
    resetDut();
    tSources();
    resetDut();
    tPulse();
    resetDut();
    tReset();
    finish_test();
  end

  // the run needs about 7k cycles; a hang past 40k counts as a miss
  initial begin
    #2000000;
    nFail++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
